// ==== common/vff_pkg.sv ====
// Constants shared by the video error-correction framer and its parity engine.
// Assumes a 20 MHz system clock and an externally supplied channel bit clock.
package vff_pkg;
  // Frame layout, bit index within one 512-bit frame
  localparam int FRAME_BITS = 512;
  localparam logic [8:0] IDX_ALIGN = 9'h000;
  localparam logic [8:0] IDX_FLAG = 9'h001;
  localparam logic [8:0] IDX_PAY_FIRST = 9'h002;
  localparam logic [8:0] IDX_PAY_LAST = 9'h1ed;
  localparam logic [8:0] IDX_PAR_FIRST = 9'h1ee;
  localparam logic [8:0] IDX_LAST = 9'h1ff;
  localparam int PAYLOAD_BITS = 492;
  localparam int PARITY_BITS = 18;
  localparam int FRAMES_PER_MULTI = 8;
  // Alignment bits of frames one to eight, first frame in the top bit
  localparam logic [7:0] ALIGN_PATTERN = 8'h1b;
  // Product of the two degree-nine factors, x^18 term implied
  localparam logic [17:0] BCH_POLY = 18'h095c9;
  localparam logic [17:0] PARITY_RESET = 18'h00000;
  // Per-picture limits and reference buffer extra size in bits
  localparam int KBIT = 1024;
  localparam logic [23:0] CIF_PIC_LIMIT = 24'h040000;
  localparam logic [23:0] QCIF_PIC_LIMIT = 24'h010000;
  localparam logic [31:0] REF_MODEL_EXTRA_BITS = 32'h00040000;
  // Picture rate times one hundred
  localparam longint PIC_RATE_X100 = 2997;
  localparam logic [3:0] WORD_BITS = 4'h8;
  localparam logic [23:0] WORD_COST = 24'h000008;
  localparam logic [7:0] UNDERRUN_WORD = 8'hff;
  typedef enum logic [1:0] {
    VFF_PH_ALIGN = 2'b00,
    VFF_PH_FLAG = 2'b01,
    VFF_PH_PAYLOAD = 2'b10,
    VFF_PH_PARITY = 2'b11
  } vff_phase_t;
endpackage : vff_pkg

// ==== rtl/vff_bch_parity.sv ====
// Systematic remainder engine for the 18 parity bits of one frame.
// Runs on the channel bit clock; the framer drives start, feed and shift.
`timescale 1ns/10ps
module vff_bch_parity (
  input wire logic clk_link,
  input wire logic link_rst,
  input wire logic start,
  input wire logic feed,
  input wire logic shift,
  input wire logic din,
  output logic par_bit
);
  import vff_pkg::*;
  logic [17:0] rem;
  logic [17:0] next_rem;
  logic fb;

  always_comb begin
    next_rem = rem;
    fb = 1'b0;
    if (start) begin
      fb = din;
      next_rem = fb ? BCH_POLY : PARITY_RESET;
    end else if (feed) begin
      fb = din ^ rem[17];
      next_rem = {rem[16:0], 1'b0} ^ (fb ? BCH_POLY : PARITY_RESET);
    end else if (shift) begin
      next_rem = {rem[16:0], 1'b0};
    end
  end

  always_ff @(posedge clk_link) begin
    if (link_rst) begin
      rem <= PARITY_RESET;
    end else begin
      rem <= next_rem;
    end
  end

  assign par_bit = rem[17];
endmodule : vff_bch_parity

// ==== rtl/vff_framer.sv ====
// Error-correction framer: source byte intake, picture budgets, buffer model,
// fast update signalling and the multiframe bit stream on the channel clock.
// Assumes clk_link is driven by the channel interface and runs continuously.
`timescale 1ns/10ps
// What this block does
// - Protect the outgoing stream with a (511,493) BCH code.
// - Parity uses the product of the two given degree-nine polynomials.
// - Eight-frame multiframe; alignment, fill flag, 492 payload, 18 parity.
// - Alignment bits over eight frames form 00011011, first frame first.
// - Parity covers fill flag plus the 492 payload bits.
// - Fill flag zero means 492 one bits plus parity, no video.
// - A bit leaves on every channel clock; gaps at a frame start give fill frames, gaps inside a data frame send ones and set underrun.
// - Picture size capped at 256 Kbit full size, 64 Kbit quarter size.
// - Picture count covers all coder bits, not framing, fill or parity.
// - Fast update request makes the next picture intra coded.
// - First picture after fast update carries the freeze release bit.
// - Output fits a reference buffer of B plus 256 Kbit.
// - At each picture tick remove all pictures completed since the last tick; occupancy at or above B sets ref_model_violation.
// - Buffer model runs synchronously with the encoder clock.
module vff_framer #(
  parameter longint R_MAX_BPS = 384000
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_link,
  input wire logic [7:0] src_data,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic pic_start,
  input wire logic pic_tick,
  input wire logic qcif_mode,
  input wire logic fast_update_pin,
  output logic force_intra,
  output logic freeze_release,
  output logic ref_model_violation,
  output logic tx_bit,
  output logic underrun
);
  import vff_pkg::*;

  localparam logic [31:0] REF_MODEL_B = 32'((4 * R_MAX_BPS * 100) / PIC_RATE_X100);
  localparam logic [31:0] REF_MODEL_CAP = REF_MODEL_B + REF_MODEL_EXTRA_BITS;

  function automatic logic [23:0] pic_limit(input logic quarter);
    pic_limit = quarter ? QCIF_PIC_LIMIT : CIF_PIC_LIMIT;
  endfunction : pic_limit

  // System clock domain
  logic req_s1, req_s2, ack_tgl, next_ack_tgl;
  logic req_tgl, next_req_tgl;
  logic [7:0] xfer_word, next_xfer_word;
  logic next_src_ready;
  logic [23:0] pic_bits, next_pic_bits;
  logic [31:0] occ, next_occ;
  logic [31:0] occ_after;
  logic [23:0] complete_bits, next_complete_bits;
  logic complete_valid, next_complete_valid, keep_valid;
  logic next_ref_model_violation;
  logic fur_s1, fur_s2, fur_s3, fur_edge;
  logic fur_pending, next_fur_pending;
  logic resp, next_resp;
  logic next_force_intra, next_freeze_release;
  logic accept, blocked;

  always_comb begin
    next_ack_tgl = ack_tgl;
    next_xfer_word = xfer_word;
    next_pic_bits = pic_bits;
    next_occ = occ;
    occ_after = occ;
    next_complete_bits = complete_bits;
    next_complete_valid = complete_valid;
    next_ref_model_violation = ref_model_violation;
    next_fur_pending = fur_pending;
    next_resp = resp;
    accept = src_valid && src_ready;
    fur_edge = fur_s2 && !fur_s3;
    keep_valid = complete_valid && !pic_tick;
    if (accept) begin
      next_xfer_word = src_data;
      next_ack_tgl = ~ack_tgl;
      next_occ = occ + 32'(WORD_COST);
    end
    if (pic_tick && complete_valid) begin
      occ_after = next_occ - 32'(complete_bits);
      next_occ = occ_after;
      next_complete_valid = 1'b0;
      if (occ_after >= REF_MODEL_B) begin
        next_ref_model_violation = 1'b1;
      end
    end
    if (pic_start) begin
      next_complete_bits = keep_valid ? complete_bits + pic_bits : pic_bits;
      next_complete_valid = 1'b1;
      next_pic_bits = accept ? WORD_COST : 24'h000000;
      next_resp = fur_pending;
      next_fur_pending = 1'b0;
    end else if (accept) begin
      next_pic_bits = pic_bits + WORD_COST;
    end
    if (fur_edge) begin
      next_fur_pending = 1'b1;
    end
    next_force_intra = next_fur_pending || next_resp;
    next_freeze_release = next_resp;
    blocked = (next_pic_bits + WORD_COST > pic_limit(qcif_mode)) ||
              (next_occ + 32'(WORD_COST) > REF_MODEL_CAP);
    next_src_ready = (req_s2 != next_ack_tgl) && !blocked;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      ack_tgl <= 1'b0;
      xfer_word <= 8'h00;
      src_ready <= 1'b0;
      pic_bits <= 24'h000000;
      occ <= 32'h00000000;
      complete_bits <= 24'h000000;
      complete_valid <= 1'b0;
      ref_model_violation <= 1'b0;
      fur_s1 <= 1'b0;
      fur_s2 <= 1'b0;
      fur_s3 <= 1'b0;
      fur_pending <= 1'b0;
      resp <= 1'b0;
      force_intra <= 1'b0;
      freeze_release <= 1'b0;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      ack_tgl <= next_ack_tgl;
      xfer_word <= next_xfer_word;
      src_ready <= next_src_ready;
      pic_bits <= next_pic_bits;
      occ <= next_occ;
      complete_bits <= next_complete_bits;
      complete_valid <= next_complete_valid;
      ref_model_violation <= next_ref_model_violation;
      fur_s1 <= fast_update_pin;
      fur_s2 <= fur_s1;
      fur_s3 <= fur_s2;
      fur_pending <= next_fur_pending;
      resp <= next_resp;
      force_intra <= next_force_intra;
      freeze_release <= next_freeze_release;
    end
  end

  // Channel clock domain
  logic link_rst_s1, link_rst;
  logic ack_s1, ack_s2;
  logic waiting, next_waiting;
  logic [7:0] nxt_word, next_nxt_word;
  logic nxt_full, next_nxt_full;
  logic [7:0] cur_word, next_cur_word;
  logic [3:0] cur_left, next_cur_left;
  logic [8:0] idx, next_idx;
  logic [2:0] frame, next_frame;
  logic fill_flag, next_fill_flag;
  logic next_tx_bit, next_underrun;
  vff_phase_t phase, next_phase;
  logic par_start, par_feed, par_shift, par_din, par_bit;

  always_ff @(posedge clk_link) begin
    link_rst_s1 <= sys_rst;
    link_rst <= link_rst_s1;
  end

  always_comb begin
    next_req_tgl = req_tgl;
    next_waiting = waiting;
    next_nxt_word = nxt_word;
    next_nxt_full = nxt_full;
    next_cur_word = cur_word;
    next_cur_left = cur_left;
    next_fill_flag = fill_flag;
    next_tx_bit = tx_bit;
    next_underrun = underrun;
    next_phase = phase;
    next_frame = frame;
    next_idx = (idx == IDX_LAST) ? IDX_ALIGN : 9'(idx + 9'h001);
    par_start = 1'b0;
    par_feed = 1'b0;
    par_shift = 1'b0;
    par_din = 1'b1;
    unique case (phase)
      VFF_PH_ALIGN: begin
        next_tx_bit = ALIGN_PATTERN[3'(3'h7 - frame)];
        next_fill_flag = nxt_full || (cur_left != 4'h0);
        next_phase = VFF_PH_FLAG;
      end
      VFF_PH_FLAG: begin
        next_tx_bit = fill_flag;
        par_start = 1'b1;
        par_din = fill_flag;
        next_phase = VFF_PH_PAYLOAD;
      end
      VFF_PH_PAYLOAD: begin
        if (!fill_flag) begin
          par_din = 1'b1;
        end else if (cur_left != 4'h0) begin
          par_din = cur_word[7];
          next_cur_word = {cur_word[6:0], 1'b0};
          next_cur_left = cur_left - 4'h1;
        end else if (nxt_full) begin
          par_din = nxt_word[7];
          next_cur_word = {nxt_word[6:0], 1'b0};
          next_cur_left = WORD_BITS - 4'h1;
          next_nxt_full = 1'b0;
        end else begin
          par_din = UNDERRUN_WORD[7];
          next_underrun = 1'b1;
        end
        next_tx_bit = par_din;
        par_feed = 1'b1;
        if (idx == IDX_PAY_LAST) begin
          next_phase = VFF_PH_PARITY;
        end
      end
      VFF_PH_PARITY: begin
        next_tx_bit = par_bit;
        par_shift = 1'b1;
        if (idx == IDX_LAST) begin
          next_phase = VFF_PH_ALIGN;
          next_frame = frame + 3'h1;
        end
      end
    endcase
    if (waiting && (ack_s2 == req_tgl)) begin
      next_nxt_word = xfer_word;
      next_nxt_full = 1'b1;
      next_waiting = 1'b0;
    end else if (!nxt_full && !waiting) begin
      next_req_tgl = ~req_tgl;
      next_waiting = 1'b1;
    end
  end

  always_ff @(posedge clk_link) begin
    if (link_rst) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      req_tgl <= 1'b0;
      waiting <= 1'b0;
      nxt_word <= 8'h00;
      nxt_full <= 1'b0;
      cur_word <= 8'h00;
      cur_left <= 4'h0;
      idx <= IDX_ALIGN;
      frame <= 3'h0;
      fill_flag <= 1'b0;
      tx_bit <= 1'b1;
      underrun <= 1'b0;
      phase <= VFF_PH_ALIGN;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      req_tgl <= next_req_tgl;
      waiting <= next_waiting;
      nxt_word <= next_nxt_word;
      nxt_full <= next_nxt_full;
      cur_word <= next_cur_word;
      cur_left <= next_cur_left;
      idx <= next_idx;
      frame <= next_frame;
      fill_flag <= next_fill_flag;
      tx_bit <= next_tx_bit;
      underrun <= next_underrun;
      phase <= next_phase;
    end
  end

  vff_bch_parity u_parity (
    .clk_link(clk_link),
    .link_rst(link_rst),
    .start(par_start),
    .feed(par_feed),
    .shift(par_shift),
    .din(par_din),
    .par_bit(par_bit)
  );

  // Checks on the channel side
  sequence s_frame_end;
    idx == IDX_LAST;
  endsequence

  sequence s_next_frame_start;
    (idx == IDX_ALIGN) && (frame == 3'($past(frame) + 3'h1));
  endsequence

  a_frame_wrap: assert property (@(posedge clk_link) disable iff (link_rst)
    s_frame_end |=> s_next_frame_start)
    else $error("frame did not wrap after 512 bits");

  a_align_bit: assert property (@(posedge clk_link) disable iff (link_rst)
    (idx == IDX_FLAG) |-> (tx_bit == ALIGN_PATTERN[3'(3'h7 - frame)]))
    else $error("alignment bit does not match pattern");

  a_flag_bit: assert property (@(posedge clk_link) disable iff (link_rst)
    (idx == IDX_PAY_FIRST) |-> (tx_bit == fill_flag))
    else $error("fill flag not sent after alignment bit");

  a_fill_ones: assert property (@(posedge clk_link) disable iff (link_rst)
    (idx > IDX_PAY_FIRST) && (idx <= IDX_PAR_FIRST) && !fill_flag |-> tx_bit)
    else $error("fill frame carried a zero payload bit");

  a_parity_span: assert property (@(posedge clk_link) disable iff (link_rst)
    (idx == IDX_PAR_FIRST) |-> (phase == VFF_PH_PARITY) ##17 (idx == IDX_LAST) ##1 (phase == VFF_PH_ALIGN))
    else $error("parity field not 18 bits long");

  // Checks on the system side
  sequence s_fur_seen;
    fur_s2 && !fur_s3;
  endsequence

  a_fur_intra: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_fur_seen |=> force_intra)
    else $error("fast update did not request intra coding");

  a_freeze_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pic_start && fur_pending |=> freeze_release && force_intra)
    else $error("freeze release missing on responding picture");

  a_pic_budget: assert property (@(posedge clk_sys) disable iff (sys_rst)
    src_valid && src_ready && $stable(qcif_mode) |=> pic_bits <= pic_limit($past(qcif_mode)))
    else $error("picture exceeded its bit budget");

  a_occ_cap: assert property (@(posedge clk_sys) disable iff (sys_rst)
    occ <= REF_MODEL_CAP)
    else $error("reference buffer overflowed");

  a_ready_drop: assert property (@(posedge clk_sys) disable iff (sys_rst)
    src_valid && src_ready |=> !src_ready ##1 (occ >= $past(occ, 2) || $past(pic_tick) || $past(pic_tick, 2)))
    else $error("ready held after a transfer");

  a_ref_model_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pic_tick && complete_valid && (occ_after >= REF_MODEL_B) |=> ref_model_violation)
    else $error("buffer check after removal not flagged");
endmodule : vff_framer

// ==== verification/vff_rx_model.sv ====
// Far-end receive model: frame hunt, alignment, parity, fill and byte recovery.
// Assumes tx_bit idles high in reset and the first zero is a frame start.
`timescale 1ns/10ps
module vff_rx_model (
  input wire logic clk_link,
  input wire logic rst,
  input wire logic tx_bit,
  output logic [7:0] rx_byte,
  output logic rx_byte_valid,
  output logic frame_done,
  output logic frame_ok,
  output logic frame_fill,
  output logic locked,
  output int lock_bits
);
  import vff_pkg::*;
  int idx;
  int fr;
  int nb;
  int good;
  bit hunt;
  bit bad;
  bit mf_bad;
  logic flag;
  logic [17:0] rem;
  logic [7:0] sh;
  always @(posedge clk_link) begin
    rx_byte_valid <= 1'b0;
    frame_done <= 1'b0;
    if (rst) begin
      hunt = 1'b1;
      nb = 0;
      good = 0;
      mf_bad = 1'b0;
      locked <= 1'b0;
    end else if (hunt) begin
      if (tx_bit === 1'b0) begin
        hunt = 1'b0;
        idx = 1;
        fr = 0;
        bad = 1'b0;
        rem = PARITY_RESET;
      end
    end else begin
      if (idx == 0) begin
        bad = (tx_bit !== ALIGN_PATTERN[7 - fr]);
        mf_bad = mf_bad | bad;
        rem = PARITY_RESET;
      end else if (idx < 494) begin
        if (idx == 1) begin
          flag = tx_bit;
        end else if (flag === 1'b1) begin
          sh = {sh[6:0], tx_bit};
          nb++;
          if (nb == 8) begin
            rx_byte <= sh;
            rx_byte_valid <= 1'b1;
            nb = 0;
          end
        end else if (tx_bit !== 1'b1) begin
          bad = 1'b1;
        end
        rem = {rem[16:0], 1'b0} ^ ((tx_bit ^ rem[17]) ? BCH_POLY : 18'h00000);
      end else begin
        if (tx_bit !== rem[17]) begin
          bad = 1'b1;
        end
        rem = {rem[16:0], 1'b0};
      end
      if (idx == 511) begin
        frame_done <= 1'b1;
        frame_ok <= !bad;
        frame_fill <= !flag;
        if (fr == 7) begin
          good = mf_bad ? 0 : good + 1;
          locked <= (good >= 3);
          mf_bad = 1'b0;
        end
        fr = (fr + 1) % 8;
      end
      idx = (idx + 1) % 512;
    end
  end
  always @(posedge clk_link) begin
    if (rst) begin
      lock_bits <= 0;
    end else if (locked !== 1'b1) begin
      lock_bits <= lock_bits + 1;
    end
  end
endmodule : vff_rx_model

// ==== verification/video_fec_framer_tb.sv ====
// Bench for the framer: source driver, picture signalling and byte scoreboard.
// Assumes the receive model watches tx_bit on the free-running channel clock.
`timescale 1ns/10ps
module video_fec_framer_tb;
  import vff_pkg::*;
  logic clk_sys, sys_rst, clk_link, src_valid, pic_start, pic_tick, qcif_mode, fast_update_pin;
  logic src_ready, force_intra, freeze_release, ref_model_violation, tx_bit, underrun;
  logic frz_done;
  int lock_bits;
  logic rx_byte_valid, frame_done, frame_ok, frame_fill, locked;
  logic [7:0] src_data;
  logic [7:0] rx_byte;
  logic [7:0] exp_q[$];
  int miscompares, compares, seed, n_taken, n_fill, n_data;
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #37;
    forever #80 clk_link = ~clk_link;
  end
  vff_framer #(.R_MAX_BPS(3000)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_link(clk_link),
    .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready), .pic_start(pic_start),
    .pic_tick(pic_tick), .qcif_mode(qcif_mode), .fast_update_pin(fast_update_pin),
    .force_intra(force_intra), .freeze_release(freeze_release), .ref_model_violation(ref_model_violation),
    .tx_bit(tx_bit), .underrun(underrun));
  vff_rx_model u_rx (.clk_link(clk_link), .rst(sys_rst), .tx_bit(tx_bit), .rx_byte(rx_byte),
    .rx_byte_valid(rx_byte_valid), .frame_done(frame_done), .frame_ok(frame_ok),
    .frame_fill(frame_fill), .locked(locked), .lock_bits(lock_bits));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys) begin
    if (src_valid === 1'b1 && src_ready === 1'b1) begin
      exp_q.push_back(src_data);
      n_taken++;
    end
  end
  always @(negedge clk_sys) begin
    src_data <= 8'($random(seed));
  end
  // Far decoder leaves its frozen picture on release
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      frz_done <= 1'b0;
    end else if (freeze_release === 1'b1) begin
      frz_done <= 1'b1;
    end
  end
  always @(negedge clk_link) begin
    if (rx_byte_valid === 1'b1) begin
      if (exp_q.size() > 0) check(rx_byte, exp_q.pop_front());
      else if (underrun !== 1'b1) check(8'h00, 8'hff);
    end
    if (frame_done === 1'b1) begin
      check({7'h00, frame_ok}, 8'h01);
      if (frame_fill === 1'b1) n_fill++;
      else n_data++;
    end
  end
  task wait_bytes(input int n);
    int t;
    t = n_taken + n;
    for (int i = 0; i < 20000 && n_taken < t; i++) @(negedge clk_sys);
    check({7'h00, n_taken >= t}, 8'h01);
  endtask : wait_bytes
  task pulse(input logic s, input logic t);
    pic_start = s;
    pic_tick = t;
    @(negedge clk_sys);
    pic_start = 1'b0;
    pic_tick = 1'b0;
    @(negedge clk_sys);
  endtask : pulse
  initial begin
    #4500000;
    miscompares++;
    give_verdict();
  end
  initial begin
    seed = 66;
    sys_rst = 1'b1;
    src_data = 8'h00;
    {src_valid, pic_start, pic_tick, qcif_mode, fast_update_pin} = 5'h00;
    repeat (10) @(negedge clk_sys);
    repeat (4) @(posedge clk_link);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    check({4'h0, force_intra, freeze_release, ref_model_violation, underrun}, 8'h00);
    repeat (2000) @(negedge clk_sys);
    src_valid = 1'b1;
    pulse(1'b1, 1'b0);
    wait_bytes(10);
    fast_update_pin = 1'b1;
    repeat (5) @(negedge clk_sys);
    check({6'h00, force_intra, freeze_release}, 8'h02);
    pulse(1'b1, 1'b0);
    check({6'h00, force_intra, freeze_release}, 8'h03);
    check({7'h00, fast_update_pin && !frz_done}, 8'h00);
    wait_bytes(5);
    pulse(1'b0, 1'b1);
    check({7'h00, ref_model_violation}, 8'h00);
    wait_bytes(5);
    qcif_mode = 1'b1;
    pulse(1'b1, 1'b0);
    check({6'h00, force_intra, freeze_release}, 8'h00);
    wait_bytes(60);
    pulse(1'b0, 1'b1);
    check({7'h00, ref_model_violation}, 8'h01);
    for (int i = 0; i < 60000 && locked !== 1'b1; i++) @(negedge clk_sys);
    check({7'h00, locked}, 8'h01);
    check({7'h00, lock_bits <= 34000}, 8'h01);
    check({7'h00, underrun}, 8'h00);
    src_valid = 1'b0;
    repeat (4000) @(negedge clk_sys);
    check({7'h00, underrun}, 8'h01);
    check({6'h00, n_fill > 0, n_data > 0}, 8'h03);
    check({7'h00, exp_q.size() == 0}, 8'h01);
    give_verdict();
  end
endmodule : video_fec_framer_tb
